// ---- tb/dtinf_checker.sv ----
// Assertion checker for the decision-tree inference block
`timescale 1ns/1ps
module dtinf_checker (
    input wire logic       mclk_in,
    input wire logic       sys_rst_in,
    input wire logic [7:0] result_out_pins,
    input wire logic       ready_out,
    input wire logic       busy_out,
    input wire logic       result_strobe_out,
    input wire logic       model_done_out,
    input wire logic       fault_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    a_ready_inverse: assert property (
        !$past(sys_rst_in) |-> ready_out != busy_out) else $error("ready not inverse of busy");
    a_strobe_single: assert property (
        $rose(result_strobe_out) |=> !result_strobe_out) else $error("strobe too long");
    a_busy_span: assert property (
        $rose(busy_out) |-> busy_out[*4] ##1 result_strobe_out) else $error("bad traversal");
    a_strobe_ends_busy: assert property (
        result_strobe_out |-> busy_out ##1 (ready_out && !busy_out))
        else $error("strobe outside run");
    a_result_held: assert property (
        !result_strobe_out && !$past(sys_rst_in) |-> $stable(result_out_pins))
        else $error("result changed without strobe");
    a_run_clears_vec: assert property (
        $rose(busy_out) |=> fault_out) else $error("vector flag kept on run");
    a_fault_after_run: assert property (
        result_strobe_out |-> fault_out) else $error("fault low after run");
    a_done_frozen: assert property (
        busy_out && $past(busy_out) |-> $stable(model_done_out)) else $error("byte taken busy");
endmodule // dtinf_checker

bind dtinf_top dtinf_checker i_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .result_out_pins(result_out_pins), .ready_out(ready_out), .busy_out(busy_out),
    .result_strobe_out(result_strobe_out), .model_done_out(model_done_out),
    .fault_out(fault_out));

// ---- tb/dtinf_host_model.sv ----
// Host-side model that streams command bytes into the block
`timescale 1ns/1ps
module dtinf_host_model (
    input  wire logic       mclk_in,
    input  wire logic       ready_in,
    output logic            valid_out,
    output logic [1:0]      cmd_out,
    output logic [7:0]      data_out
);
    initial begin
        valid_out = 1'b0;
        cmd_out = 2'h3;
        data_out = 8'h00;
    end
    // One byte for each cycle of valid
    task automatic send(input logic [1:0] c, input logic [7:0] d);
        valid_out <= 1'b1;
        cmd_out <= c;
        data_out <= d;
        @(posedge mclk_in);
    endtask
    // Released pins carry no stale byte
    task automatic idle(input int n);
        int w;
        w = 0;
        valid_out <= 1'b0;
        cmd_out <= ~cmd_out;
        data_out <= ~data_out;
        repeat (n) @(posedge mclk_in);
        while (ready_in !== 1'b1 && w < 20) begin
            @(posedge mclk_in);
            w++;
        end
    endtask
endmodule // dtinf_host_model

// ---- tb/dtinf_top_tb.sv ----
// Self-checking testbench for the decision-tree inference block
`timescale 1ns/1ps
module dtinf_top_tb;
    logic       mclk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic [1:0] reg_addr_in;
    logic [7:0] reg_wdata_in;
    logic       reg_wr_in;
    logic       reg_rd_in;
    logic       valid_in, irq_out, ready_out, busy_out, result_strobe_out;
    logic       model_done_out, fault_out;
    logic [1:0] cmd_sel_in;
    logic [7:0] payload_in_pins, reg_rdata_out, result_out_pins, rd;
    int         miscompares;
    int         checks_done;
    logic [7:0] mdl [22] = '{8'h02, 8'h18, 8'h00, 8'h08, 8'h07, 8'h23, 8'h04, 8'h14, 8'h01,
        8'h14, 8'h06, 8'h28, 8'h03, 8'h1C, 8'h08, 8'h12, 8'h19, 8'h2D, 8'h37, 8'h55, 8'h5F, 8'h8C};
    logic [7:0] feat [2][8] = '{'{8'hFF, 8'hFF, 8'h45, 8'h20, 8'h00, 8'h04, 8'h00, 8'h00},
        '{8'h04, 8'h06, 8'h0A, 8'h0C, 8'h0F, 8'h14, 8'h0A, 8'h12}};

    dtinf_top i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .payload_in_pins(payload_in_pins), .valid_in(valid_in), .cmd_sel_in(cmd_sel_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
        .result_out_pins(result_out_pins), .ready_out(ready_out), .busy_out(busy_out),
        .result_strobe_out(result_strobe_out), .model_done_out(model_done_out),
        .fault_out(fault_out));
    dtinf_host_model i_host (.mclk_in(mclk_in), .ready_in(ready_out), .valid_out(valid_in),
        .cmd_out(cmd_sel_in), .data_out(payload_in_pins));

    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic reg_rd(input logic [1:0] a);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(negedge mclk_in);
        rd = reg_rdata_out;
        @(posedge mclk_in);
    endtask
    function automatic logic [7:0] predict(input int k);
        int i;
        i = 0;
        repeat (3) i = (feat[k][mdl[2*i][2:0]] < mdl[2*i+1]) ? 2*i+1 : 2*i+2;
        return mdl[i+7];
    endfunction
    task automatic close_out();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge mclk_in);
        miscompares++;
        close_out();
    end
    initial begin
        reg_addr_in <= 2'h0;
        reg_wdata_in <= 8'h00;
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        repeat (5) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(negedge mclk_in);
        @(negedge mclk_in);
        chk("ready", {7'h00, ready_out}, 8'h01);
        chk("fault", {7'h00, fault_out}, 8'h01);
        @(posedge mclk_in);
        reg_wr(2'h1, 8'h02);
        i_host.send(2'h2, 8'h01);
        i_host.idle(8);
        reg_rd(2'h0);
        chk("status", rd & 8'h03, 8'h02);
        chk("irq", {7'h00, irq_out}, 8'h01);
        reg_rd(2'h3);
        chk("unmapped", rd, 8'h00);
        reg_wr(2'h0, 8'h02);
        reg_rd(2'h0);
        chk("status clear", rd & 8'h02, 8'h00);
        chk("irq clear", {7'h00, irq_out}, 8'h00);
        repeat (5) i_host.send(2'h0, 8'h11);
        i_host.send(2'h2, 8'h02);
        i_host.idle(4);
        for (int i = 0; i < 21; i++) i_host.send(2'h0, mdl[i]);
        i_host.idle(4);
        chk("done early", {7'h00, model_done_out}, 8'h00);
        i_host.send(2'h0, mdl[21]);
        i_host.idle(4);
        chk("done", {7'h00, model_done_out}, 8'h01);
        for (int k = 0; k < 2; k++) begin
            for (int j = 0; j < 8; j++) begin
                i_host.send(2'h1, feat[k][j]);
                if (j == 3) i_host.send(2'h3, 8'hFF);
            end
            i_host.idle(4);
            chk("fault loaded", {7'h00, fault_out}, 8'h00);
            i_host.send(2'h2, 8'h01);
            i_host.idle(1);
            repeat (2) @(negedge mclk_in);
            chk("busy", {7'h00, busy_out}, 8'h01);
            chk("ready low", {7'h00, ready_out}, 8'h00);
            for (int n = 0; n < 20 && result_strobe_out !== 1'b1; n++) @(negedge mclk_in);
            chk("prediction", result_out_pins, predict(k));
            chk("fault after", {7'h00, fault_out}, 8'h01);
            @(negedge mclk_in);
            chk("strobe end", {7'h00, result_strobe_out}, 8'h00);
            chk("busy end", {7'h00, busy_out}, 8'h00);
            @(posedge mclk_in);
        end
        reg_wr(2'h0, 8'h07);
        i_host.send(2'h2, 8'h01);
        i_host.idle(8);
        reg_rd(2'h0);
        chk("rerun", rd & 8'h03, 8'h02);
        i_host.send(2'h0, 8'h02);
        i_host.idle(4);
        chk("restart", {7'h00, model_done_out}, 8'h00);
        close_out();
    end
endmodule // dtinf_top_tb

// ---- verilog/dtinf_regs.vh ----
// Constants for the decision-tree inference block
`ifndef DTINF_REGS_VH
`define DTINF_REGS_VH
`define DTINF_CMD_MODEL     2'h0
`define DTINF_CMD_FEATURE   2'h1
`define DTINF_CMD_CTRL      2'h2
`define DTINF_CTRL_RUN      0
`define DTINF_CTRL_CLEAR    1
`define DTINF_MODEL_BYTES   5'h16
`define DTINF_MODEL_LAST    5'h15
`define DTINF_LEAF_BASE     5'h0E
`define DTINF_FEAT_LAST     3'h7
`define DTINF_LEAF_FIRST    3'h7
`define DTINF_LEVELS        2'h3
`define DTINF_REG_STATUS    2'h0
`define DTINF_REG_MASK      2'h1
`define DTINF_IRQ_RESULT    0
`define DTINF_IRQ_ERROR     1
`define DTINF_IRQ_MODEL     2
`endif

// ---- verilog/dtinf_top.v ----
// Decision-tree inference engine with byte-wide command interface
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "dtinf_regs.vh"

module dtinf_top (
    input  wire       mclk_in,
    input  wire       sys_rst_in,
    input  wire [7:0] payload_in_pins,
    input  wire       valid_in,
    input  wire [1:0] cmd_sel_in,
    input  wire [1:0] reg_addr_in,
    input  wire [7:0] reg_wdata_in,
    input  wire       reg_wr_in,
    input  wire       reg_rd_in,
    output reg  [7:0] reg_rdata_out,
    output reg        irq_out,
    output reg  [7:0] result_out_pins,
    output reg        ready_out,
    output reg        busy_out,
    output reg        result_strobe_out,
    output reg        model_done_out,
    output reg        fault_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WALK = 2'h1;
    localparam ST_DONE = 2'h2;

    // Pin synchronisers
    reg  [7:0] pay_s1;
    reg  [7:0] pay_s2;
    reg        val_s1;
    reg        val_s2;
    reg  [1:0] cmd_s1;
    reg  [1:0] cmd_s2;

    reg  [7:0] model_mem [0:21];
    reg  [7:0] feat_mem  [0:7];
    reg  [4:0] model_pos;
    reg  [2:0] feat_pos;
    reg        model_done;
    reg        feat_done;
    reg        err_flag;
    reg        busy;
    reg  [1:0] state;
    reg  [2:0] node;
    reg  [1:0] level;
    reg  [2:0] irq_status;
    reg  [2:0] irq_mask;
    reg  [2:0] leaf_off;

    wire       accept;
    wire       take_model;
    wire       take_feat;
    wire       is_ctrl;
    wire       do_clear;
    wire       do_run;
    wire       run_ok;
    wire [7:0] attr_byte;
    wire [7:0] thr_byte;
    wire [7:0] feat_val;
    wire       go_left;
    wire [3:0] child;
    wire [7:0] leaf_val;
    wire [2:0] irq_events;
    wire [4:0] leaf_addr;

    // No byte while the ready pin is low, even as busy drops
    assign accept     = val_s2 & ready_out & ~busy;
    assign take_model = accept & (cmd_s2 == `DTINF_CMD_MODEL);
    assign take_feat  = accept & (cmd_s2 == `DTINF_CMD_FEATURE);
    assign is_ctrl    = accept & (cmd_s2 == `DTINF_CMD_CTRL);
    assign do_clear   = is_ctrl & pay_s2[`DTINF_CTRL_CLEAR];
    assign do_run     = is_ctrl & pay_s2[`DTINF_CTRL_RUN] & ~do_clear;
    assign run_ok     = model_done & feat_done;
    // Node record: attribute index byte, then threshold byte
    assign attr_byte  = model_mem[{1'b0, node, 1'b0}];
    assign thr_byte   = model_mem[{1'b0, node, 1'b1}];
    assign feat_val   = feat_mem[attr_byte[2:0]];
    assign go_left    = feat_val < thr_byte;
    assign child      = go_left ? ({node, 1'b0} + 4'h1) : ({node, 1'b0} + 4'h2);
    assign leaf_addr  = `DTINF_LEAF_BASE + {2'h0, leaf_off};
    assign leaf_val   = model_mem[leaf_addr];
    assign irq_events = {take_model & (model_pos == `DTINF_MODEL_LAST),
                         do_run & ~run_ok,
                         state == ST_DONE};

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pay_s1 <= 8'h00;
            pay_s2 <= 8'h00;
            val_s1 <= 1'b0;
            val_s2 <= 1'b0;
            cmd_s1 <= 2'h0;
            cmd_s2 <= 2'h0;
        end else begin
            pay_s1 <= payload_in_pins;
            pay_s2 <= pay_s1;
            val_s1 <= valid_in;
            val_s2 <= val_s1;
            cmd_s1 <= cmd_sel_in;
            cmd_s2 <= cmd_s1;
        end
    end

    // Storage, cleared by command
    genvar gi;
    generate
        for (gi = 0; gi < 22; gi = gi + 1) begin : g_model
            always @(posedge mclk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    model_mem[gi] <= 8'h00;
                end else if (do_clear) begin
                    model_mem[gi] <= 8'h00;
                end else if (take_model && model_pos == gi) begin
                    model_mem[gi] <= pay_s2;
                end
            end
        end
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_feat
            always @(posedge mclk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    feat_mem[gi] <= 8'h00;
                end else if (do_clear) begin
                    feat_mem[gi] <= 8'h00;
                end else if (take_feat && feat_pos == gi) begin
                    feat_mem[gi] <= pay_s2;
                end
            end
        end
    endgenerate

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            model_pos  <= 5'h00;
            feat_pos   <= 3'h0;
            model_done <= 1'b0;
            feat_done  <= 1'b0;
            err_flag   <= 1'b0;
        end else if (do_clear) begin
            model_pos  <= 5'h00;
            feat_pos   <= 3'h0;
            model_done <= 1'b0;
            feat_done  <= 1'b0;
            err_flag   <= 1'b0;
        end else begin
            if (take_model) begin
                if (model_pos == `DTINF_MODEL_LAST) begin
                    model_pos  <= 5'h00;
                    model_done <= 1'b1;
                end else begin
                    model_pos <= model_pos + 5'h01;
                    if (model_pos == 5'h00) begin
                        model_done <= 1'b0;
                    end
                end
            end
            if (take_feat) begin
                feat_pos <= feat_pos + 3'h1;
                if (feat_pos == `DTINF_FEAT_LAST) begin
                    feat_done <= 1'b1;
                end else if (feat_pos == 3'h0) begin
                    feat_done <= 1'b0;
                end
            end
            if (do_run) begin
                feat_done <= 1'b0;
                if (!run_ok) begin
                    err_flag <= 1'b1;
                end
            end
        end
    end

    // Traversal core
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
            node  <= 3'h0;
            level <= 2'h0;
        end else if (do_clear) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
            node  <= 3'h0;
            level <= 2'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (do_run && run_ok) begin
                        state <= ST_WALK;
                        busy  <= 1'b1;
                        node  <= 3'h0;
                        level <= 2'h0;
                    end
                end
                ST_WALK: begin
                    level <= level + 2'h1;
                    if (level == `DTINF_LEVELS - 2'h1) begin
                        node  <= child[3:0] >= 4'h7 ? child[2:0] - 3'h7 + 3'h7 : 3'h0;
                        state <= ST_DONE;
                    end else begin
                        node <= child[2:0];
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // Leaf index kept in node only up to 7; hold full leaf offset separately
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            leaf_off <= 3'h0;
        end else if (state == ST_WALK && level == `DTINF_LEVELS - 2'h1) begin
            leaf_off <= child[2:0] + 3'h1;
        end
    end

    // Output pins
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            result_out_pins   <= 8'h00;
            result_strobe_out <= 1'b0;
            ready_out         <= 1'b0;
            busy_out          <= 1'b0;
            model_done_out    <= 1'b0;
            fault_out         <= 1'b0;
        end else begin
            result_strobe_out <= (state == ST_DONE) & ~do_clear;
            if (state == ST_DONE && !do_clear) begin
                result_out_pins <= leaf_val;
            end
            ready_out      <= ~(busy | (state == ST_IDLE & do_run & run_ok)) | do_clear;
            busy_out       <= (busy | (state == ST_IDLE & do_run & run_ok)) & ~do_clear;
            model_done_out <= model_done;
            fault_out      <= err_flag | ~feat_done;
        end
    end

    // Interrupt status, mask and register port
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_status    <= 3'h0;
            irq_mask      <= 3'h0;
            irq_out       <= 1'b0;
            reg_rdata_out <= 8'h00;
        end else begin
            if (reg_wr_in && reg_addr_in == `DTINF_REG_STATUS) begin
                irq_status <= (irq_status & ~reg_wdata_in[2:0]) | irq_events;
            end else begin
                irq_status <= irq_status | irq_events;
            end
            if (reg_wr_in && reg_addr_in == `DTINF_REG_MASK) begin
                irq_mask <= reg_wdata_in[2:0];
            end
            irq_out <= |(irq_status & irq_mask);
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `DTINF_REG_STATUS: reg_rdata_out <= {5'h00, irq_status};
                    `DTINF_REG_MASK:   reg_rdata_out <= {5'h00, irq_mask};
                    default:           reg_rdata_out <= 8'h00;
                endcase
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end
endmodule // dtinf_top
